/* design/prog_space_map.sv */
// Program space decoder, vectors, stack, readout lock and pin sharing
`timescale 1ns/100ps
module prog_space_map import prog_space_pkg::*; #(
	parameter bit ERASABLE = 1'b1
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic fetch_valid,
	input wire logic [PC_W-1:0] fetch_addr,
	input wire logic vec_req,
	input wire vec_kind_t vec_kind,
	input wire logic [1:0] irq_index,
	input wire logic nmi_pin,
	input wire logic nmi_ack,
	input wire logic test_prog_level,
	input wire logic readout_opt,
	input wire logic full_erase,
	input wire logic ext_read_req,
	input wire logic [PC_W-1:0] ext_read_addr,
	input wire logic stack_push,
	input wire logic stack_pop,
	input wire logic [PC_W-1:0] stack_push_addr,
	input wire logic timer_out_enable,
	input wire logic reload_timer_output,
	input wire logic port_b_gpio7,
	input wire logic port_b_line6,
	output logic boot_fetch_valid,
	output logic [PC_W-1:0] boot_fetch_addr,
	output logic vec_addr_valid,
	output logic [PC_W-1:0] vec_addr_lo,
	output logic [PC_W-1:0] vec_addr_hi,
	output region_t fetch_region,
	output logic access_error,
	output logic nmi_pending,
	output logic prog_mode,
	output logic readout_locked,
	output logic ext_read_grant,
	output logic ext_read_refused,
	output logic [PC_W-1:0] stack_top,
	output logic [2:0] stack_level,
	output logic stack_overflow,
	output logic stack_underflow,
	output logic port_b_line7,
	output logic reload_timer_input
);

	////////////////////////////////////////////////////////////////////////////////
	// Region decoding

	function automatic region_t region_of(input logic [PC_W-1:0] a);
		if (a < USER_LO)
			return REG_RESERVED_LOW;
		else if (a <= USER_HI)
			return REG_USER;
		else if (a <= RSV_TOP_HI)
			return REG_RESERVED_TOP;
		else if (a <= IRQ_VEC_HI)
			return REG_IRQ_VEC;
		else if (a <= RSV_VEC_HI)
			return REG_RESERVED_VEC;
		else if (a <= NMI_VEC_HI)
			return REG_NMI_VEC;
		else
			return REG_RESET_VEC;
	endfunction

	function automatic logic is_reserved(input region_t r);
		return (r == REG_RESERVED_LOW) || (r == REG_RESERVED_TOP) || (r == REG_RESERVED_VEC);
	endfunction

	wire region_t fetch_decode = region_of(fetch_addr);
	wire logic fetch_bad = fetch_valid && is_reserved(fetch_decode);
	wire logic [PC_W-1:0] irq_base = IRQ_VEC_LO + {9'h000, irq_index, 1'b0};

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fetch_region <= REG_RESET_VEC;
			access_error <= 1'b0;
		end else begin
			if (fetch_valid)
				fetch_region <= fetch_decode;
			access_error <= fetch_bad;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Start vector fetch after reset

	boot_state_t boot_state;
	boot_state_t next_boot_state;

	assign next_boot_state = (boot_state == BOOT_LO) ? BOOT_HI : BOOT_RUN;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_state <= BOOT_LO;
			boot_fetch_valid <= 1'b1;
			boot_fetch_addr <= RST_VEC_LO;
		end else begin
			boot_state <= next_boot_state;
			boot_fetch_valid <= (next_boot_state != BOOT_RUN);
			boot_fetch_addr <= RST_VEC_HI;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Vector lookup

	wire logic [PC_W-1:0] next_vec_lo = (vec_kind == VEC_NMI) ? NMI_VEC_LO :
		(vec_kind == VEC_RESET) ? RST_VEC_LO : irq_base;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			vec_addr_valid <= 1'b0;
			vec_addr_lo <= ADDR_ZERO;
			vec_addr_hi <= ADDR_ZERO;
		end else begin
			vec_addr_valid <= vec_req;
			if (vec_req) begin
				vec_addr_lo <= next_vec_lo;
				vec_addr_hi <= next_vec_lo + 12'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Non-maskable request

	logic nmi_sync1;
	logic nmi_sync2;
	logic nmi_sync3;
	wire logic nmi_edge = nmi_sync3 && !nmi_sync2;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			nmi_sync1 <= 1'b1;
			nmi_sync2 <= 1'b1;
			nmi_sync3 <= 1'b1;
			nmi_pending <= 1'b0;
		end else begin
			nmi_sync1 <= nmi_pin;
			nmi_sync2 <= nmi_sync1;
			nmi_sync3 <= nmi_sync2;
			if (nmi_edge)
				nmi_pending <= 1'b1;
			else if (nmi_ack)
				nmi_pending <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Programming mode strap and readout lock

	logic strap_armed;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_armed <= 1'b1;
			prog_mode <= 1'b0;
		end else if (strap_armed) begin
			strap_armed <= 1'b0;
			prog_mode <= test_prog_level;
		end
	end

	wire logic lock_now = readout_opt || readout_locked;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			readout_locked <= 1'b0;
			ext_read_grant <= 1'b0;
			ext_read_refused <= 1'b0;
		end else begin
			if (readout_opt)
				readout_locked <= 1'b1;
			else if (full_erase && ERASABLE)
				readout_locked <= 1'b0;
			ext_read_grant <= ext_read_req && !lock_now && !is_reserved(region_of(ext_read_addr));
			ext_read_refused <= ext_read_req && lock_now;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Return address stack

	logic [PC_W-1:0] stack_mem [STACK_DEPTH];
	wire logic do_push = stack_push && (stack_level != LEVEL_FULL);
	wire logic do_pop = stack_pop && !stack_push && (stack_level != LEVEL_ZERO);
	wire logic [2:0] below_top = stack_level - 3'h2;

	always_ff @(posedge core_clk) begin
		if (do_push)
			stack_mem[stack_level] <= stack_push_addr;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stack_level <= LEVEL_ZERO;
			stack_top <= ADDR_ZERO;
			stack_overflow <= 1'b0;
			stack_underflow <= 1'b0;
		end else begin
			stack_overflow <= stack_push && (stack_level == LEVEL_FULL);
			stack_underflow <= stack_pop && !stack_push && (stack_level == LEVEL_ZERO);
			if (do_push) begin
				stack_level <= stack_level + LEVEL_ONE;
				stack_top <= stack_push_addr;
			end else if (do_pop) begin
				stack_level <= stack_level - LEVEL_ONE;
				stack_top <= (stack_level == LEVEL_ONE) ? ADDR_ZERO : stack_mem[below_top];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Port B pin sharing

	wire logic next_line7 = timer_out_enable ? reload_timer_output : port_b_gpio7;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_b_line7 <= 1'b0;
			reload_timer_input <= 1'b0;
		end else begin
			port_b_line7 <= next_line7;
			reload_timer_input <= port_b_line6;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	sequence boot_lo_s;
		boot_fetch_valid && boot_fetch_addr == RST_VEC_LO;
	endsequence

	sequence boot_hi_s;
		boot_fetch_valid && boot_fetch_addr == RST_VEC_HI;
	endsequence

	chk_boot_vector_order: assert property (@(posedge core_clk) disable iff (!rst_n)
		rst_n ##0 boot_lo_s |=> boot_hi_s ##1 !boot_fetch_valid)
		else $error("reset vector fetch order wrong");

	chk_nmi_vector_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
		vec_req && vec_kind == VEC_NMI |=>
		vec_addr_valid && vec_addr_lo == NMI_VEC_LO && vec_addr_hi == NMI_VEC_HI)
		else $error("nmi vector address wrong");

	chk_irq_vector_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
		vec_req && vec_kind == VEC_IRQ |=> vec_addr_lo == $past(irq_base)
		&& vec_addr_lo >= IRQ_VEC_LO && vec_addr_hi <= IRQ_VEC_HI)
		else $error("interrupt vector outside table");

	chk_user_fetch_ok: assert property (@(posedge core_clk) disable iff (!rst_n)
		fetch_valid && fetch_addr >= USER_LO && fetch_addr <= USER_HI |=>
		!access_error && fetch_region == REG_USER)
		else $error("user fetch flagged");

	chk_reserved_fetch_err: assert property (@(posedge core_clk) disable iff (!rst_n)
		fetch_valid && (fetch_addr < USER_LO || (fetch_addr >= RSV_TOP_LO && fetch_addr <= RSV_TOP_HI)
		|| (fetch_addr >= RSV_VEC_LO && fetch_addr <= RSV_VEC_HI)) |=> access_error)
		else $error("reserved fetch not flagged");

	chk_nmi_fall_pending: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(nmi_pin) |-> ##3 nmi_pending)
		else $error("nmi edge lost");

	chk_nmi_hold_pending: assert property (@(posedge core_clk) disable iff (!rst_n)
		nmi_pending && !nmi_ack |=> nmi_pending)
		else $error("nmi request dropped early");

	chk_readout_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
		ext_read_req && readout_opt |=> ext_read_refused && !ext_read_grant)
		else $error("protected readout granted");

	chk_lock_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
		readout_locked && !full_erase |=> readout_locked)
		else $error("readout lock cleared without erase");

	chk_strap_stable: assert property (@(posedge core_clk) disable iff (!rst_n)
		!strap_armed |=> $stable(prog_mode))
		else $error("programming mode changed after reset");

	chk_stack_push_top: assert property (@(posedge core_clk) disable iff (!rst_n)
		stack_push && stack_level < LEVEL_FULL |=>
		stack_top == $past(stack_push_addr) && stack_level == $past(stack_level) + LEVEL_ONE)
		else $error("stack push lost");

	chk_stack_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
		stack_level <= LEVEL_FULL)
		else $error("stack deeper than six");

	chk_line7_select: assert property (@(posedge core_clk) disable iff (!rst_n)
		rst_n |=> port_b_line7 == $past(timer_out_enable ? reload_timer_output : port_b_gpio7))
		else $error("port line7 source wrong");

endmodule // prog_space_map

/* design/prog_space_pkg.sv */
// Constants and types for the program space map block
package prog_space_pkg;
	localparam int PC_W = 12;
	localparam int STACK_DEPTH = 6;
	localparam logic [11:0] USER_LO = 12'h080;
	localparam logic [11:0] USER_HI = 12'hf9f;
	localparam logic [11:0] RSV_TOP_LO = 12'hfa0;
	localparam logic [11:0] RSV_TOP_HI = 12'hfef;
	localparam logic [11:0] IRQ_VEC_LO = 12'hff0;
	localparam logic [11:0] IRQ_VEC_HI = 12'hff7;
	localparam logic [11:0] RSV_VEC_LO = 12'hff8;
	localparam logic [11:0] RSV_VEC_HI = 12'hffb;
	localparam logic [11:0] NMI_VEC_LO = 12'hffc;
	localparam logic [11:0] NMI_VEC_HI = 12'hffd;
	localparam logic [11:0] RST_VEC_LO = 12'hffe;
	localparam logic [11:0] RST_VEC_HI = 12'hfff;
	localparam logic [7:0] RESERVED_FILL = 8'hff;
	localparam logic [11:0] ADDR_ZERO = 12'h000;
	localparam logic [2:0] LEVEL_ZERO = 3'h0;
	localparam logic [2:0] LEVEL_ONE = 3'h1;
	localparam logic [2:0] LEVEL_FULL = 3'h6;

	typedef enum logic [2:0] {
		REG_RESERVED_LOW = 3'h0,
		REG_USER = 3'h1,
		REG_RESERVED_TOP = 3'h2,
		REG_IRQ_VEC = 3'h3,
		REG_RESERVED_VEC = 3'h4,
		REG_NMI_VEC = 3'h5,
		REG_RESET_VEC = 3'h6
	} region_t;

	typedef enum logic [1:0] {
		VEC_IRQ = 2'h0,
		VEC_NMI = 2'h1,
		VEC_RESET = 2'h2
	} vec_kind_t;

	typedef enum logic [1:0] {
		BOOT_LO = 2'h0,
		BOOT_HI = 2'h1,
		BOOT_RUN = 2'h3
	} boot_state_t;
endpackage

/* sim/core_model.sv */
// Core side model: fetch strobes and nmi vector acceptance
`timescale 1ns/100ps
module core_model import prog_space_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic cmd_fetch,
	input wire logic [11:0] cmd_addr,
	input wire logic nmi_pending,
	output logic fetch_valid,
	output logic [11:0] fetch_addr,
	output logic nmi_ack,
	output logic [7:0] fetch_data
);
	logic [2:0] wait_cnt;
	// Image: code bytes read 00, reserved bytes hold the fill
	wire logic code_addr = (cmd_addr >= USER_LO && cmd_addr <= USER_HI) ||
		(cmd_addr >= IRQ_VEC_LO && cmd_addr <= IRQ_VEC_HI) || cmd_addr >= NMI_VEC_LO;
	////////////////////////////////////////////////////////////////////////////////
	// Idle address is scrambled, ack comes late
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fetch_valid <= 1'b0;
			fetch_addr <= 12'h000;
			nmi_ack <= 1'b0;
			wait_cnt <= 3'h0;
			fetch_data <= 8'h00;
		end else begin
			fetch_valid <= cmd_fetch;
			if (cmd_fetch)
				fetch_data <= code_addr ? 8'h00 : RESERVED_FILL;
			fetch_addr <= cmd_fetch ? cmd_addr : ~fetch_addr;
			nmi_ack <= nmi_pending && wait_cnt == 3'h4;
			wait_cnt <= (nmi_pending && !nmi_ack) ? wait_cnt + 3'h1 : 3'h0;
		end
	end
endmodule // core_model

/* sim/prog_space_map_bench.sv */
// Testbench for the program space map block
`timescale 1ns/100ps
module prog_space_map_bench import prog_space_pkg::*;;
	logic core_clk = 0, rst_n = 0, cmd_fetch = 0, vec_req = 0, nmi_pin = 1, readout_opt = 0;
	logic ext_read_req = 0, stack_push = 0, stack_pop = 0, timer_out_enable = 0;
	logic reload_timer_output = 0, port_b_gpio7 = 0;
	logic test_prog_level = 0;
	logic full_erase = 0, port_b_line6 = 0;
	logic [7:0] fetch_data;
	logic [11:0] cmd_addr = 12'h000, ext_read_addr = 12'h000, stack_push_addr = 12'h000;
	vec_kind_t vec_kind = VEC_IRQ;
	logic [1:0] irq_index = 2'h0;
	logic fetch_valid, nmi_ack, boot_fetch_valid, vec_addr_valid, access_error, nmi_pending;
	logic prog_mode, readout_locked, ext_read_grant, ext_read_refused, stack_overflow;
	logic stack_underflow, port_b_line7, reload_timer_input;
	logic [11:0] fetch_addr, boot_fetch_addr, vec_addr_lo, vec_addr_hi, stack_top;
	logic [2:0] stack_level;
	region_t fetch_region;
	int n_fail = 0, total_checks = 0;
	core_model core_model_inst (.core_clk(core_clk), .rst_n(rst_n), .cmd_fetch(cmd_fetch),
		.cmd_addr(cmd_addr), .nmi_pending(nmi_pending), .fetch_valid(fetch_valid),
		.fetch_addr(fetch_addr), .nmi_ack(nmi_ack), .fetch_data(fetch_data));
	prog_space_map prog_space_map_inst (.core_clk(core_clk), .rst_n(rst_n),
		.fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .vec_req(vec_req),
		.vec_kind(vec_kind), .irq_index(irq_index), .nmi_pin(nmi_pin), .nmi_ack(nmi_ack),
		.test_prog_level(test_prog_level), .readout_opt(readout_opt), .full_erase(full_erase),
		.ext_read_req(ext_read_req), .ext_read_addr(ext_read_addr), .stack_push(stack_push),
		.stack_pop(stack_pop), .stack_push_addr(stack_push_addr),
		.timer_out_enable(timer_out_enable), .reload_timer_output(reload_timer_output),
		.port_b_gpio7(port_b_gpio7), .port_b_line6(port_b_line6),
		.boot_fetch_valid(boot_fetch_valid),
		.boot_fetch_addr(boot_fetch_addr), .vec_addr_valid(vec_addr_valid),
		.vec_addr_lo(vec_addr_lo), .vec_addr_hi(vec_addr_hi), .fetch_region(fetch_region),
		.access_error(access_error), .nmi_pending(nmi_pending), .prog_mode(prog_mode),
		.readout_locked(readout_locked), .ext_read_grant(ext_read_grant),
		.ext_read_refused(ext_read_refused), .stack_top(stack_top), .stack_level(stack_level),
		.stack_overflow(stack_overflow), .stack_underflow(stack_underflow),
		.port_b_line7(port_b_line7), .reload_timer_input(reload_timer_input));
	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wait_pend(input logic lvl);
		int i;
		for (i = 0; i < 40 && nmi_pending !== lvl; i++) begin
			@(posedge core_clk);
			#1;
		end
		chk("nmi_pending", 12'(nmi_pending), 12'(lvl));
		if (nmi_pending !== lvl) wrap_up();
	endtask
	task automatic rd(input logic [11:0] a, input logic g, input logic r);
		@(posedge core_clk);
		ext_read_req <= 1'b1;
		ext_read_addr <= a;
		@(posedge core_clk);
		ext_read_req <= 1'b0;
		#1;
		chk("read_grant", 12'(ext_read_grant), 12'(g));
		chk("read_refused", 12'(ext_read_refused), 12'(r));
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic test_boot;
		chk("boot_valid", 12'(boot_fetch_valid), 12'h001);
		chk("boot_addr", boot_fetch_addr, RST_VEC_LO);
		@(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		#1;
		chk("boot_addr2", boot_fetch_addr, RST_VEC_HI);
		chk("prog_mode", 12'(prog_mode), 12'h000);
		@(posedge core_clk);
		#1;
		chk("boot_end", 12'(boot_fetch_valid), 12'h000);
		$display("test boot done");
	endtask
	task automatic test_fetch;
		logic [11:0] t [14] = '{12'h000, 12'h07f, 12'h080, 12'hf9f, 12'hfa0, 12'hfef, 12'hff0,
			12'hff7, 12'hff8, 12'hffb, 12'hffc, 12'hffd, 12'hffe, 12'hfff};
		for (int i = 0; i < 14; i++) begin
			@(posedge core_clk);
			cmd_fetch <= 1'b1;
			cmd_addr <= t[i];
			@(posedge core_clk);
			cmd_fetch <= 1'b0;
			@(posedge core_clk);
			#1;
			chk("region", 12'(fetch_region), 12'(i / 2));
			chk("access_error", 12'(access_error), 12'((i / 2) % 2 == 0 && i < 12));
			chk("image_fill", 12'(fetch_data == RESERVED_FILL), 12'((i / 2) % 2 == 0 && i < 12));
		end
		$display("test fetch done");
	endtask
	task automatic test_vec;
		logic [11:0] lo;
		for (int k = 0; k < 6; k++) begin
			lo = k < 4 ? IRQ_VEC_LO + 12'(2 * k) : (k == 4 ? NMI_VEC_LO : RST_VEC_LO);
			@(posedge core_clk);
			vec_req <= 1'b1;
			vec_kind <= k < 4 ? VEC_IRQ : (k == 4 ? VEC_NMI : VEC_RESET);
			irq_index <= 2'(k);
			@(posedge core_clk);
			vec_req <= 1'b0;
			#1;
			chk("vec_valid", 12'(vec_addr_valid), 12'h001);
			chk("vec_lo", vec_addr_lo, lo);
			chk("vec_hi", vec_addr_hi, lo + 12'h001);
			@(posedge core_clk);
			#1;
			chk("vec_valid_end", 12'(vec_addr_valid), 12'h000);
		end
		$display("test vectors done");
	endtask
	task automatic test_nmi;
		@(posedge core_clk);
		nmi_pin <= 1'b0;
		wait_pend(1'b1);
		@(posedge core_clk);
		nmi_pin <= 1'b1;
		@(posedge core_clk);
		nmi_pin <= 1'b0;
		wait_pend(1'b0);
		repeat (8) @(posedge core_clk);
		#1;
		chk("nmi_merged", 12'(nmi_pending), 12'h000);
		$display("test nmi done");
	endtask
	task automatic test_read;
		rd(12'h100, 1'b1, 1'b0);
		rd(12'h000, 1'b0, 1'b0);
		@(posedge core_clk);
		readout_opt <= 1'b1;
		rd(12'h100, 1'b0, 1'b1);
		@(posedge core_clk);
		readout_opt <= 1'b0;
		rd(12'h100, 1'b0, 1'b1);
		chk("locked", 12'(readout_locked), 12'h001);
		@(posedge core_clk);
		full_erase <= 1'b1;
		@(posedge core_clk);
		full_erase <= 1'b0;
		#1;
		chk("erased", 12'(readout_locked), 12'h000);
		rd(12'h100, 1'b1, 1'b0);
		$display("test readout done");
	endtask
	task automatic test_stack;
		for (int i = 0; i < 7; i++) begin
			@(posedge core_clk);
			stack_push <= 1'b1;
			stack_push_addr <= 12'h100 + 12'(i);
			@(posedge core_clk);
			stack_push <= 1'b0;
			#1;
			chk("push_level", 12'(stack_level), 12'(i < 6 ? i + 1 : 6));
			chk("push_top", stack_top, 12'h100 + 12'(i < 6 ? i : 5));
			chk("overflow", 12'(stack_overflow), 12'(i == 6));
		end
		for (int i = 0; i < 7; i++) begin
			@(posedge core_clk);
			stack_pop <= 1'b1;
			@(posedge core_clk);
			stack_pop <= 1'b0;
			#1;
			chk("pop_level", 12'(stack_level), 12'(i < 6 ? 5 - i : 0));
			chk("pop_top", stack_top, i < 5 ? 12'h104 - 12'(i) : 12'h000);
			chk("underflow", 12'(stack_underflow), 12'(i == 6));
		end
		$display("test stack done");
	endtask
	task automatic test_line7;
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			timer_out_enable <= i[1];
			reload_timer_output <= i[0];
			port_b_gpio7 <= !i[0];
			port_b_line6 <= i[0];
			@(posedge core_clk);
			#1;
			chk("line7", 12'(port_b_line7), 12'(i[1] ? i[0] : !i[0]));
			chk("line6_in", 12'(reload_timer_input), 12'(i[0]));
		end
		$display("test line7 done");
	endtask
	task automatic test_strap;
		@(posedge core_clk);
		test_prog_level <= 1'b1;
		rst_n <= 1'b0;
		@(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		test_prog_level <= 1'b0;
		#1;
		chk("strap_high", 12'(prog_mode), 12'h001);
		chk("boot_again", boot_fetch_addr, RST_VEC_HI);
		@(posedge core_clk);
		#1;
		chk("strap_held", 12'(prog_mode), 12'h001);
		chk("boot_end2", 12'(boot_fetch_valid), 12'h000);
		@(posedge core_clk);
		rst_n <= 1'b0;
		@(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		#1;
		chk("strap_low", 12'(prog_mode), 12'h000);
		$display("test strap done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Clock and main sequence
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		repeat (10) @(posedge core_clk);
		#1;
		test_boot();
		test_fetch();
		test_vec();
		test_nmi();
		test_read();
		test_stack();
		test_line7();
		test_strap();
		wrap_up();
	end
endmodule // prog_space_map_bench
